// ===== uart9_pkg.sv
// Notes on behaviour
// - frame is start low, eight data lsb first, ninth bit, stop high
// - mode 2 bit rate is cpu clock over 16 or over 32
// - mode 3 bit rate comes from timer 1 overflow ticks
// - data buffer write loads ninth bit into shifter and requests transmit
// - transmit starts after next divide-by-16 rollover
// - start bit, then shifter output, first shift inserts a one
// - last shift ends frame, done flag at eleventh rollover after write
// - falling edge resets counter and loads all ones into input shifter
// - each bit sampled at counter states 7, 8, 9 with majority vote
// - start bit not zero resets receiver to edge search
// - bits shift in from right; start at left triggers final load
// - load only if done flag clear and filter off or ninth bit one
// - one bit time after final shift receiver returns to edge search
// - filter ignored in mode 0; in mode 1 requires valid stop bit
// - with filter in modes 2 and 3 address must match given or broadcast
// - given match compares only bits where mask is one
// - broadcast is address or mask; zero bits are don't-care
// - address and mask reset to zero so everything matches
// - sixteen counter states split a bit; rollover marks bit boundary
package uart9_pkg;
  localparam int  UART9_OVS       = 16;
  localparam int  UART9_SAMPLE_A  = 7;
  localparam int  UART9_SAMPLE_B  = 8;
  localparam int  UART9_SAMPLE_C  = 9;
  localparam int  UART9_TX_BITS   = 11;
  localparam logic [8:0] UART9_RX_INIT = 9'h1FF;
  localparam logic [7:0] UART9_ADDR_RST = 8'h00;
  localparam logic [1:0] UART9_MODE0 = 2'h0;
  localparam logic [1:0] UART9_MODE1 = 2'h1;
  localparam logic [1:0] UART9_MODE2 = 2'h2;
  localparam logic [1:0] UART9_MODE3 = 2'h3;

  typedef enum logic [1:0] {UART9_RX_IDLE, UART9_RX_BITS, UART9_RX_TAIL}
    uart9_rx_state_t;

  // majority of three samples
  function automatic logic uart9_vote(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : uart9_vote
endpackage : uart9_pkg

// ===== uart9_fifo.sv
`timescale 1ns/1ps
// small receive buffer between the shifter and software
module uart9_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("uart9_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : uart9_fifo

// ===== uart9_core.sv
`timescale 1ns/1ps
module uart9_core
  import uart9_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // configuration
  input  wire logic [1:0] MODE,
  input  wire logic       DOUBLE_RATE,
  input  wire logic       TIMER1_OVF,
  input  wire logic       MULTIPROC_FILTER_ENABLE,
  input  wire logic [7:0] NODE_ADDRESS_IN,
  input  wire logic [7:0] NODE_ADDRESS_MASK_IN,
  input  wire logic       ADDR_WE,
  // transmit side of serial data buffer
  input  wire logic       SERIAL_DATA_BUFFER_WE,
  input  wire logic [7:0] SERIAL_DATA_BUFFER_WDATA,
  input  wire logic       TX_NINTH_BIT,
  // serial control register flag clears
  input  wire logic       TX_DONE_CLR,
  input  wire logic       RX_DONE_CLR,
  // receive buffer read
  input  wire logic       RX_READ,
  output logic [7:0]      SERIAL_DATA_BUFFER_RDATA,
  output logic            RX_NINTH_BIT,
  output logic            RX_DATA_VALID,
  // status
  output logic            TX_DONE_FLAG,
  output logic            RX_DONE_FLAG,
  output logic            TX_BUSY,
  output logic [7:0]      NODE_ADDRESS,
  output logic [7:0]      NODE_ADDRESS_MASK,
  // serial lines
  input  wire logic       RXD,
  output logic            TXD
);
  if (FIFO_DEPTH < 2)
  begin : g_bad_depth
    $error("uart9_core fifo depth too small");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic rxd_s1_q, rxd_q, rxd_prev_q;
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rxd_s1_q   <= 1'b1;
      rxd_q      <= 1'b1;
      rxd_prev_q <= 1'b1;
    end
    else
    begin
      rxd_s1_q   <= RXD;
      rxd_q      <= rxd_s1_q;
      rxd_prev_q <= rxd_q;
    end
  end

  // ----------------------------------------------------------------
  // oversample tick: every clock or every second clock in mode 2
  // ----------------------------------------------------------------
  logic pre_q;
  // sixteen ticks make a bit, so a bit is 16 or 32 clocks; any wider
  // divider here would put the bit rate off by the oversampling factor
  wire pre_wrap = DOUBLE_RATE | pre_q;
  wire tick = (MODE == UART9_MODE2) ? pre_wrap : TIMER1_OVF;
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      pre_q <= '0;
    else
      pre_q <= ~pre_wrap;
  end

  // ----------------------------------------------------------------
  // node address and mask
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      NODE_ADDRESS      <= UART9_ADDR_RST;
      NODE_ADDRESS_MASK <= UART9_ADDR_RST;
    end
    else if (ADDR_WE)
    begin
      NODE_ADDRESS      <= NODE_ADDRESS_IN;
      NODE_ADDRESS_MASK <= NODE_ADDRESS_MASK_IN;
    end
  end

  // ----------------------------------------------------------------
  // transmitter: free running divide-by-16 sets bit boundaries
  // ----------------------------------------------------------------
  logic [3:0] tx_div_q;
  logic       tx_req_q, tx_send_q, tx_data_q;
  logic [8:0] tx_sh_q;
  logic [1:0] tx_lead_q;
  wire tx_roll = tick && (tx_div_q == 4'(UART9_OVS - 1));
  // done when ninth bit at output, stop bit left of it, zeros above
  wire tx_last = (tx_sh_q[8:2] == 7'h00) && tx_sh_q[1];
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      tx_div_q <= '0;
    else if (tick)
      tx_div_q <= tx_div_q + 4'h1;
  end
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_req_q  <= 1'b0;
      tx_send_q <= 1'b0;
      tx_data_q <= 1'b0;
      tx_lead_q <= '0;
      tx_sh_q   <= '0;
      TXD       <= 1'b1;
    end
    else
    begin
      if (SERIAL_DATA_BUFFER_WE && !tx_send_q)
      begin
        tx_sh_q  <= {TX_NINTH_BIT, SERIAL_DATA_BUFFER_WDATA};
        tx_req_q <= 1'b1;
      end
      else if (tx_roll)
      begin
        if (tx_req_q)
        begin
          tx_req_q  <= 1'b0;
          tx_send_q <= 1'b1;
          TXD       <= 1'b0;    // start bit
          tx_lead_q <= 2'd1;
        end
        else if (tx_send_q && tx_lead_q == 2'd1)
        begin
          tx_lead_q <= 2'd2;
          tx_data_q <= 1'b1;
          TXD       <= tx_sh_q[0];
        end
        else if (tx_send_q && tx_lead_q == 2'd2)
        begin
          tx_lead_q <= 2'd0;
          tx_sh_q   <= {1'b1, tx_sh_q[8:1]}; // first shift inserts stop
          TXD       <= tx_sh_q[1];
        end
        else if (tx_send_q && tx_last)
        begin
          tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
          tx_send_q <= 1'b0;
          tx_data_q <= 1'b0;
          TXD       <= 1'b1;
        end
        else if (tx_send_q)
        begin
          tx_sh_q <= {1'b0, tx_sh_q[8:1]};
          TXD     <= tx_sh_q[1];
        end
      end
    end
  end
  assign TX_BUSY = tx_req_q | tx_send_q;
  wire tx_end = tx_roll && tx_send_q && tx_lead_q == 2'd0 && tx_last;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  uart9_rx_state_t rx_st_q;
  logic [3:0] rx_div_q;
  logic [2:0] rx_smp_q;
  logic [8:0] rx_sh_q;
  logic       rx_start_q;
  wire falling = rxd_prev_q & ~rxd_q;
  wire rx_roll = tick && (rx_div_q == 4'(UART9_OVS - 1));
  wire bit_val = uart9_vote(rx_smp_q);
  wire [8:0] rx_shifted = {rx_sh_q[7:0], bit_val};
  // the start bit reaches the left edge after the eighth data bit; the
  // ninth data bit (or stop in mode 1) is the incoming bit on that shift
  wire rx_final = rx_roll && rx_st_q == UART9_RX_BITS
                  && !rx_start_q && !rx_sh_q[8];
  wire nine_bit_mode = MODE[1];
  // the first data bit ends up leftmost, so the byte is turned round
  wire [7:0] data_rx = {<<{rx_shifted[8:1]}};
  wire given_ok = ((data_rx ^ NODE_ADDRESS) & NODE_ADDRESS_MASK) == 8'h00;
  wire [7:0] bcast = NODE_ADDRESS | NODE_ADDRESS_MASK;
  wire bcast_ok = ((~data_rx) & bcast) == 8'h00;
  wire filter_on = MULTIPROC_FILTER_ENABLE && (MODE != UART9_MODE0);
  wire addr_ok = !nine_bit_mode || given_ok || bcast_ok;
  wire accept = !RX_DONE_FLAG && (!filter_on || (bit_val && addr_ok));
  wire fifo_ready;
  wire rx_push = rx_final && accept && fifo_ready;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_st_q    <= UART9_RX_IDLE;
      rx_div_q   <= '0;
      rx_smp_q   <= '0;
      rx_sh_q    <= '0;
      rx_start_q <= 1'b0;
    end
    else
    begin
      unique case (rx_st_q)
        UART9_RX_IDLE:
          if (falling)
          begin
            rx_div_q   <= '0;
            rx_sh_q    <= UART9_RX_INIT;
            rx_start_q <= 1'b1;
            rx_st_q    <= UART9_RX_BITS;
          end
        UART9_RX_BITS:
          if (tick)
          begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == 4'(UART9_SAMPLE_A - 1))
              rx_smp_q[0] <= rxd_q;
            if (rx_div_q == 4'(UART9_SAMPLE_B - 1))
              rx_smp_q[1] <= rxd_q;
            if (rx_div_q == 4'(UART9_SAMPLE_C - 1))
              rx_smp_q[2] <= rxd_q;
            if (rx_roll)
            begin
              rx_start_q <= 1'b0;
              if (rx_start_q && bit_val)
                rx_st_q <= UART9_RX_IDLE;  // false start
              else if (rx_final)
              begin
                rx_sh_q <= rx_shifted;
                rx_st_q <= UART9_RX_TAIL;
              end
              else
                rx_sh_q <= rx_shifted;
            end
          end
        UART9_RX_TAIL:
          if (tick)
          begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_roll)
              rx_st_q <= UART9_RX_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // done flags: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      TX_DONE_FLAG <= 1'b0;
      RX_DONE_FLAG <= 1'b0;
      RX_NINTH_BIT <= 1'b0;
    end
    else
    begin
      if (tx_end)
        TX_DONE_FLAG <= 1'b1;
      else if (TX_DONE_CLR)
        TX_DONE_FLAG <= 1'b0;
      if (rx_push)
      begin
        RX_DONE_FLAG <= 1'b1;
        RX_NINTH_BIT <= bit_val;
      end
      else if (RX_DONE_CLR)
        RX_DONE_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer; a full buffer drops the frame like a set flag
  // ----------------------------------------------------------------
  logic [7:0] fifo_out;
  uart9_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (rx_final && accept),
    .in_ready  (fifo_ready),
    .in_data   (data_rx),
    .out_valid (RX_DATA_VALID),
    .out_ready (RX_READ),
    .out_data  (fifo_out)
  );
  assign SERIAL_DATA_BUFFER_RDATA = fifo_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_addr_reset: assert property (@(posedge SYS_CLK)
    $rose(!RST) |-> NODE_ADDRESS == 8'h00 && NODE_ADDRESS_MASK == 8'h00)
    else $error("address not cleared by reset");
  a_rx_drop_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_final && RX_DONE_FLAG |-> !rx_push)
    else $error("frame loaded while done flag set");
  a_rx_filter: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_push && filter_on |-> bit_val)
    else $error("filtered frame accepted with ninth bit low");
  a_false_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_roll && rx_start_q && bit_val && rx_st_q == UART9_RX_BITS
    |=> rx_st_q == UART9_RX_IDLE)
    else $error("false start not rejected");
  a_rx_tail: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_final |=> rx_st_q == UART9_RX_TAIL)
    else $error("no tail after final shift");
  a_tx_start_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(tx_send_q) |-> !TXD)
    else $error("start bit not low");
  a_tx_idle_high: assert property (@(posedge SYS_CLK) disable iff (RST)
    !tx_send_q |-> TXD)
    else $error("line not high when idle");
  a_tx_flag_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    tx_end |=> TX_DONE_FLAG)
    else $error("transmit done flag missed");
  a_edge_load: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_st_q == UART9_RX_IDLE && falling |=> rx_sh_q == UART9_RX_INIT)
    else $error("input shifter not preset");
  c_tx_frame: cover property (@(posedge SYS_CLK) disable iff (RST) tx_end);
  c_rx_frame: cover property (@(posedge SYS_CLK) disable iff (RST) rx_push);
  a_start_bit: assert property (@(posedge SYS_CLK) disable iff (RST)
    tx_send_q && !tx_data_q |-> !TXD)
    else $error("line not low during start bit");
  a_push_state: assert property (@(posedge SYS_CLK) disable iff (RST)
    rx_push |-> rx_st_q == UART9_RX_BITS && !rx_start_q)
    else $error("frame loaded outside the bit phase");
  a_done_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    TX_DONE_FLAG && !TX_DONE_CLR |=> TX_DONE_FLAG)
    else $error("transmit done flag dropped without clear");
  c_rx_drop:  cover property (@(posedge SYS_CLK) disable iff (RST)
    rx_final && !accept);
  c_false_start: cover property (@(posedge SYS_CLK) disable iff (RST)
    rx_roll && rx_start_q && bit_val && rx_st_q == UART9_RX_BITS);
endmodule : uart9_core

// ===== uart9_peer.sv
`timescale 1ns/1ps
// far node on the serial pair; drives its line only at falling edges
module uart9_peer (
  // clock and bit period in clocks
  input  wire logic        clk,
  input  wire logic [15:0] bit_clks,
  // serial lines
  input  wire logic        line_in,
  output logic             line_out,
  // last frame heard: stop, ninth, data
  output logic [9:0]       got_word,
  output logic [15:0]      got_cnt
);
  // ---------------------------------------------------------------------
  // sender
  // ---------------------------------------------------------------------
  task automatic send(input logic [7:0] data, input logic ninth);
    logic [10:0] frame;
    frame = {1'b1, ninth, data, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out = frame[i];
      repeat (bit_clks) @(negedge clk);
    end
    // an idle bit lets the far receiver finish its tail bit
    repeat (bit_clks) @(negedge clk);
  endtask : send

  // short low pulse that must not be taken for a start bit
  task automatic glitch(input int n);
    line_out = 1'b0;
    repeat (n) @(negedge clk);
    line_out = 1'b1;
    // long enough for a wrongly taken frame to raise its done flag
    repeat (12 * bit_clks) @(negedge clk);
  endtask : glitch

  // ---------------------------------------------------------------------
  // receiver, samples mid bit
  // ---------------------------------------------------------------------
  initial
  begin
    line_out = 1'b1;
    got_word = '0;
    got_cnt  = '0;
    forever
    begin
      @(negedge line_in);
      repeat (bit_clks / 2) @(negedge clk);
      for (int i = 0; i < 10; i++)
      begin
        repeat (bit_clks) @(negedge clk);
        got_word = {line_in, got_word[9:1]};
      end
      got_cnt = got_cnt + 16'h1;
    end
  end
endmodule : uart9_peer

// ===== uart_nine_bit_addressed_modes_bench.sv
`timescale 1ns/1ps
module uart_nine_bit_addressed_modes_bench;
  logic        SYS_CLK, RST, DOUBLE_RATE, TIMER1_OVF, FILT, ADDR_WE, WE;
  logic        TX_NINTH_BIT, TX_DONE_CLR, RX_DONE_CLR, RX_READ, RX_NINTH_BIT;
  logic        RX_DATA_VALID, TX_DONE_FLAG, RX_DONE_FLAG, TX_BUSY, RXD, TXD;
  logic [1:0]  MODE, tcnt;
  logic [7:0]  ADDR_IN, MASK_IN, WDATA, RDATA, NODE_ADDRESS, NODE_ADDRESS_MASK;
  logic [9:0]  got_word;
  logic [15:0] got_cnt, bitc;
  logic [7:0]  addr, mask;
  logic        filt, rxf, last9;
  logic [8:0]  q[$];
  int          errors, n_checks;
  logic [7:0]  tbl[4] = '{8'hC2, 8'hC1, 8'hFF, 8'h80};

  uart9_core #(.FIFO_DEPTH(4)) i_dut (
    .SYS_CLK(SYS_CLK), .RST(RST), .MODE(MODE), .DOUBLE_RATE(DOUBLE_RATE),
    .TIMER1_OVF(TIMER1_OVF), .MULTIPROC_FILTER_ENABLE(FILT),
    .NODE_ADDRESS_IN(ADDR_IN), .NODE_ADDRESS_MASK_IN(MASK_IN),
    .ADDR_WE(ADDR_WE), .SERIAL_DATA_BUFFER_WE(WE),
    .SERIAL_DATA_BUFFER_WDATA(WDATA), .TX_NINTH_BIT(TX_NINTH_BIT),
    .TX_DONE_CLR(TX_DONE_CLR), .RX_DONE_CLR(RX_DONE_CLR), .RX_READ(RX_READ),
    .SERIAL_DATA_BUFFER_RDATA(RDATA), .RX_NINTH_BIT(RX_NINTH_BIT),
    .RX_DATA_VALID(RX_DATA_VALID), .TX_DONE_FLAG(TX_DONE_FLAG),
    .RX_DONE_FLAG(RX_DONE_FLAG), .TX_BUSY(TX_BUSY),
    .NODE_ADDRESS(NODE_ADDRESS), .NODE_ADDRESS_MASK(NODE_ADDRESS_MASK),
    .RXD(RXD), .TXD(TXD));

  uart9_peer i_peer (.clk(SYS_CLK), .bit_clks(bitc), .line_in(TXD),
    .line_out(RXD), .got_word(got_word), .got_cnt(got_cnt));

  // ---------------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      errors++;
      end_of_test();
    end
  endtask : bound

  function automatic logic accept(input logic [7:0] d, input logic n9);
    logic [7:0] b;
    b = addr | mask;
    return !rxf && q.size() < 4 && (!filt || (n9 && (MODE == 2'h1
      || ((d ^ addr) & mask) == 8'h00
      || (d & b) == b)));
  endfunction : accept

  // ---------------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------------
  task automatic tx(input logic [7:0] d, input logic n9);
    logic [15:0] c0;
    int          k;
    c0 = got_cnt;
    WDATA = d;
    TX_NINTH_BIT = n9;
    WE = 1'b1;
    @(negedge SYS_CLK);
    WE = 1'b0;
    chk(TX_BUSY, 1);
    repeat (3 * bitc) @(negedge SYS_CLK);
    // a write while sending must be ignored
    WDATA = ~d;
    WE = 1'b1;
    @(negedge SYS_CLK);
    WE = 1'b0;
    for (k = 0; got_cnt == c0 && k < 13 * bitc; k++) @(negedge SYS_CLK);
    bound(k, 13 * bitc);
    chk(got_word, {1'b1, n9, d});
    for (k = 0; TX_DONE_FLAG !== 1'b1 && k < bitc; k++) @(negedge SYS_CLK);
    chk(TX_DONE_FLAG, 1);
    repeat (bitc) @(negedge SYS_CLK);
    chk(TX_DONE_FLAG, 1);
    chk(TX_BUSY, 0);
    TX_DONE_CLR = 1'b1;
    @(negedge SYS_CLK);
    TX_DONE_CLR = 1'b0;
    @(negedge SYS_CLK);
    chk(TX_DONE_FLAG, 0);
  endtask : tx

  task automatic rx(input logic [7:0] d, input logic n9, input logic clr);
    logic a;
    a = accept(d, n9);
    i_peer.send(d, n9);
    rxf = rxf | a;
    if (a)
    begin
      q.push_back({n9, d});
      last9 = n9;
    end
    chk(RX_DONE_FLAG, rxf);
    chk(RX_NINTH_BIT, last9);
    if (clr)
    begin
      RX_DONE_CLR = 1'b1;
      @(negedge SYS_CLK);
      RX_DONE_CLR = 1'b0;
      rxf = 1'b0;
    end
  endtask : rx

  // reader stalls at random between pops
  task automatic drain;
    while (q.size() > 0)
    begin
      repeat ($urandom_range(3)) @(negedge SYS_CLK);
      chk(RX_DATA_VALID, 1);
      chk(RDATA, q[0][7:0]);
      RX_READ = 1'b1;
      @(negedge SYS_CLK);
      RX_READ = 1'b0;
      void'(q.pop_front());
    end
    chk(RX_DATA_VALID, 0);
  endtask : drain

  // ---------------------------------------------------------------------
  // clock, timer overflow ticks and main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  always @(negedge SYS_CLK)
  begin
    tcnt <= tcnt + 2'h1;
    TIMER1_OVF <= (tcnt == 2'h3);
  end

  initial
  begin
    {RST, ADDR_WE, WE, TX_DONE_CLR, RX_DONE_CLR, RX_READ} = 6'h20;
    {TX_NINTH_BIT, TIMER1_OVF, FILT, filt, rxf, last9} = 6'h00;
    {MODE, DOUBLE_RATE, tcnt, bitc} = {2'h2, 1'b1, 2'h0, 16'h0010};
    {ADDR_IN, MASK_IN, WDATA, addr, mask} = 40'h0;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RST = 1'b0;
    void'($urandom(32'h5CCC));
    chk({TXD, TX_DONE_FLAG, RX_DONE_FLAG}, 3'h4);
    chk({NODE_ADDRESS, NODE_ADDRESS_MASK}, 16'h0000);
    for (int c = 0; c < 3; c++)
    begin
      MODE = (c == 2) ? 2'h3 : 2'h2;
      DOUBLE_RATE = (c == 0);
      bitc = (c == 0) ? 16'h0010 : (c == 1) ? 16'h0020 : 16'h0040;
      tx($urandom, $urandom);
      rx($urandom, $urandom, 1);
      drain();
    end
    {MODE, DOUBLE_RATE, bitc} = {2'h2, 1'b1, 16'h0010};
    FILT = 1'b1;
    filt = 1'b1;
    rx($urandom, 1, 1);
    rx($urandom, 0, 1);
    {ADDR_IN, MASK_IN, ADDR_WE, addr, mask} = {8'hC0, 8'hFD, 1'b1, 16'hC0FD};
    @(negedge SYS_CLK);
    ADDR_WE = 1'b0;
    chk({NODE_ADDRESS, NODE_ADDRESS_MASK}, 16'hC0FD);
    for (int i = 0; i < 6; i++)
      rx((i < 4) ? tbl[i] : $urandom, 1, 1);
    drain();
    // mode 1: the filter checks only the bit in the stop position
    {MODE, bitc} = {2'h1, 16'h0040};
    rx(tbl[3], 1, 1);
    rx(tbl[2], 0, 1);
    {MODE, bitc} = {2'h2, 16'h0010};
    FILT = 1'b0;
    filt = 1'b0;
    rx($urandom, 0, 0);
    rx($urandom, 1, 1);
    i_peer.glitch(4);
    chk(RX_DONE_FLAG, 0);
    for (int i = 0; i < 5; i++)
      rx($urandom, $urandom, 1);
    drain();
    end_of_test();
  end
endmodule : uart_nine_bit_addressed_modes_bench
